// ===== logic/sadc_top.sv
// Four-channel six-bit converter control with register port and interrupt.
// Operation
// - Successive approximation gives six-bit results.
// - Each channel has its own result latch.
// - Clearing enable bit makes pin analog.
// - Inputs 0,1 share gpio; 2,3 share PWM.
// - Clearing start bit begins a conversion.
// - Done flag sets when results are valid.
// - Done interrupt enable bit, reset zero.
// - Only enabled channels get valid results.
// - Reset: control all ones, converter stopped.
// - Reset clears enable and pending request.
// - Latch reset values C0 and 00.
// - Channels 2,3 stay PWM after reset.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "sadc_map.svh"
module sadc_top #(
    parameter int CHANNELS = 4,
    parameter int BITS = 6
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Register port.
    input wire sadc_pkg::sadc_bus_s BUS,
    output logic [7:0] RDATA,
    // Analog front end.
    input wire logic CMP_HI,
    output logic [CHANNELS-1:0] CH_SELECT,
    output sadc_pkg::sadc_code_t TRIAL_CODE,
    output logic [CHANNELS-1:0] PIN_IS_ANALOG,
    // Interrupt.
    output logic IRQ
);
    import sadc_pkg::*;

    localparam int STEP = `SADC_STEP_CYCLES;

    logic [7:0] control_reg;
    logic [BITS-1:0] result_reg [CHANNELS];
    logic [7:0] result0_top_reg;
    logic done_flag_reg;
    logic irq_enable_reg;
    logic [1:0] chan_reg;
    logic cmp_sync;
    logic sar_go;
    logic sar_busy;
    logic sar_done;
    logic [BITS-1:0] sar_trial;
    sadc_state_e state_reg;
    logic [CHANNELS-1:0] active;
    logic start_write;
    logic clear_write;
    logic [7:0] rdata_next;

    if (CHANNELS != 4 || BITS != 6)
    begin
        $error("sadc_top: only four channels of six bits are supported");
    end

    function automatic logic hit(input sadc_bus_s b, input logic [7:0] ofs);
        hit = b.addr == ofs;
    endfunction

    assign active = ~control_reg[CHANNELS-1:0];
    assign start_write = BUS.wr && hit(BUS, `SADC_OFS_CONTROL)
        && !BUS.wdata[`SADC_BIT_START];
    assign clear_write = BUS.wr && hit(BUS, `SADC_OFS_IRQ_REQUEST)
        && BUS.wdata[`SADC_BIT_DONE];

    sadc_sync #(.WIDTH(1)) u_cmp_sync (
        .clk(CLK),
        .rstn(RSTN),
        .d(CMP_HI),
        .q(cmp_sync)
    );

    sadc_sar #(.BITS(BITS), .STEP(STEP)) u_sar (
        .clk(CLK),
        .rstn(RSTN),
        .go(sar_go),
        .cmp_hi(cmp_sync),
        .trial(sar_trial),
        .busy(sar_busy),
        .done(sar_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control register: write-only, all ones after reset.

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            control_reg <= `SADC_RST_CONTROL;
        else if (BUS.wr && hit(BUS, `SADC_OFS_CONTROL))
            control_reg <= BUS.wdata;
        else if (state_reg == SADC_DONE)
            control_reg[`SADC_BIT_START] <= 1'b1;
    end

    // Analog-pin select: enabled channel pins leave their port or PWM role.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            PIN_IS_ANALOG <= '0;
        else
            PIN_IS_ANALOG <= active;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer: walks all four channels once per start.

    always_ff @(posedge CLK)
    begin
        sar_go <= 1'b0;
        if (!RSTN)
        begin
            state_reg <= SADC_IDLE;
            chan_reg <= '0;
        end
        else
        begin
            case (state_reg)
                SADC_IDLE:
                begin
                    // Starting with no channel enabled still completes and flags done.
                    if (start_write)
                    begin
                        chan_reg <= '0;
                        state_reg <= SADC_SAMPLE;
                        sar_go <= 1'b1;
                    end
                end
                SADC_SAMPLE:
                begin
                    if (sar_done)
                    begin
                        if (chan_reg == 2'(CHANNELS - 1))
                            state_reg <= SADC_DONE;
                        else
                        begin
                            chan_reg <= chan_reg + 2'd1;
                            sar_go <= 1'b1;
                        end
                    end
                end
                SADC_DONE:
                    state_reg <= SADC_IDLE;
                default:
                    state_reg <= SADC_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            CH_SELECT <= '0;
            TRIAL_CODE <= '0;
        end
        else
        begin
            CH_SELECT <= (state_reg == SADC_SAMPLE) ? (4'b0001 << chan_reg) : '0;
            TRIAL_CODE <= sar_trial;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Result latches: only enabled channels are updated.

    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++)
        begin : g_latch
            always_ff @(posedge CLK)
            begin
                if (!RSTN)
                    result_reg[gi] <= '0;
                else if (sar_done && chan_reg == 2'(gi) && active[gi])
                    result_reg[gi] <= sar_trial;
            end
        end
    endgenerate

    // Latch 0 resets to C0; its upper bits stay as reset and read back unchanged.
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            result0_top_reg <= `SADC_RST_RESULT0;
        else
            result0_top_reg <= result0_top_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Done flag and interrupt. Set wins over a simultaneous clear.

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            done_flag_reg <= 1'b0;
        else if (state_reg == SADC_DONE)
            done_flag_reg <= 1'b1;
        else if (clear_write)
            done_flag_reg <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            irq_enable_reg <= 1'b0;
        else if (BUS.wr && hit(BUS, `SADC_OFS_IRQ_ENABLE))
            irq_enable_reg <= BUS.wdata[`SADC_BIT_DONE];
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            IRQ <= 1'b0;
        else
            IRQ <= done_flag_reg && irq_enable_reg;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the read strobe, zero elsewhere.

    always_comb
    begin
        rdata_next = 8'h00;
        if (BUS.rd)
        begin
            case (BUS.addr)
                `SADC_OFS_RESULT0: rdata_next = {result0_top_reg[7:6], result_reg[0]};
                `SADC_OFS_RESULT1: rdata_next = {2'b00, result_reg[1]};
                `SADC_OFS_RESULT2: rdata_next = {2'b00, result_reg[2]};
                `SADC_OFS_RESULT3: rdata_next = {2'b00, result_reg[3]};
                `SADC_OFS_IRQ_ENABLE: rdata_next = 8'({irq_enable_reg, 3'b000});
                `SADC_OFS_IRQ_REQUEST: rdata_next = 8'({done_flag_reg, 3'b000});
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            RDATA <= 8'h00;
        else
            RDATA <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_start_runs: assert property (@(posedge CLK) disable iff (!RSTN)
        start_write && state_reg == SADC_IDLE |=> state_reg == SADC_SAMPLE)
        else $error("start write did not begin conversion");
    a_done_sets: assert property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_DONE |=> done_flag_reg)
        else $error("done flag not set");
    a_clear_works: assert property (@(posedge CLK) disable iff (!RSTN)
        clear_write && state_reg != SADC_DONE |=> !done_flag_reg)
        else $error("clear did not clear flag");
    a_irq_follows: assert property (@(posedge CLK) disable iff (!RSTN)
        IRQ == $past(done_flag_reg && irq_enable_reg))
        else $error("irq does not follow flag and enable");
    a_reset_ctrl: assert property (@(posedge CLK)
        !RSTN |=> control_reg == `SADC_RST_CONTROL && state_reg == SADC_IDLE)
        else $error("reset did not restore control");
    a_reset_irq: assert property (@(posedge CLK)
        !RSTN |=> !done_flag_reg && !irq_enable_reg && !IRQ)
        else $error("reset did not clear interrupt");
    a_reset_latch: assert property (@(posedge CLK)
        !RSTN |=> result0_top_reg == `SADC_RST_RESULT0 && result_reg[1] == '0)
        else $error("latch reset value wrong");
    a_disabled_hold: assert property (@(posedge CLK) disable iff (!RSTN)
        !active[1] |=> $stable(result_reg[1]))
        else $error("disabled channel latch changed");
    a_pin_analog: assert property (@(posedge CLK) disable iff (!RSTN)
        PIN_IS_ANALOG == $past(active))
        else $error("pin role does not follow enable");
    a_enable_bit: assert property (@(posedge CLK) disable iff (!RSTN)
        BUS.wr && hit(BUS, `SADC_OFS_IRQ_ENABLE) |=> irq_enable_reg == $past(BUS.wdata[3]))
        else $error("enable bit not written");
    a_idle_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_IDLE |-> !sar_busy)
        else $error("approximation running while sequencer idle");
    a_start_returns: assert property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_DONE && !(BUS.wr && hit(BUS, `SADC_OFS_CONTROL))
        |=> control_reg[`SADC_BIT_START])
        else $error("start bit not returned to inactive");
    a_select_idle: assert property (@(posedge CLK) disable iff (!RSTN)
        state_reg != SADC_SAMPLE |=> CH_SELECT == '0)
        else $error("channel selected while not converting");

    c_conversion: cover property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_DONE);
    c_irq: cover property (@(posedge CLK) disable iff (!RSTN) IRQ);
    c_masked_done: cover property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_DONE && !irq_enable_reg);
    c_set_clear: cover property (@(posedge CLK) disable iff (!RSTN)
        state_reg == SADC_DONE && clear_write);
endmodule

// ===== logic/sadc_map.svh
// Register offsets, field positions, reset values and timing counts of the converter block.
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
`define SADC_OFS_CONTROL 8'h10
`define SADC_OFS_RESULT0 8'h11
`define SADC_OFS_RESULT1 8'h12
`define SADC_OFS_RESULT2 8'h13
`define SADC_OFS_RESULT3 8'h14
`define SADC_OFS_IRQ_ENABLE 8'h1B
`define SADC_OFS_IRQ_REQUEST 8'h1E
`define SADC_BIT_START 7
`define SADC_BIT_DONE 3
`define SADC_RST_CONTROL 8'hFF
`define SADC_RST_RESULT0 8'hC0
`define SADC_RST_RESULTN 8'h00
`define SADC_RST_IRQ 8'h00
`define SADC_STEP_NS 500
`define SADC_CLK_NS 50
`define SADC_STEP_CYCLES ((`SADC_STEP_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`endif

// ===== logic/sadc_pkg.sv
// Types shared by the converter control block.
package sadc_pkg;
    typedef logic [5:0] sadc_code_t;
    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sadc_bus_s;
    typedef enum logic [1:0] {SADC_IDLE, SADC_SAMPLE, SADC_DONE} sadc_state_e;
endpackage

// ===== logic/sadc_sync.sv
// Two-flop synchroniser for the comparator decision.
`timescale 1ns/100ps
module sadc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Data.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// ===== logic/sadc_sar.sv
// Successive-approximation sequencer producing one code per trial sequence.
`timescale 1ns/100ps
module sadc_sar
    import sadc_pkg::*;
#(
    parameter int BITS = 6,
    parameter int STEP = 10
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Control.
    input wire logic go,
    input wire logic cmp_hi,
    output logic [BITS-1:0] trial,
    output logic busy,
    output logic done
);
    logic [BITS-1:0] mask_reg;
    logic [15:0] wait_reg;

    // Refused at elaboration; the upper STEP limit is there because the step counter is only sixteen bits wide.
    if (BITS < 1 || BITS > 16 || STEP < 1 || STEP > 65535)
    begin
        $error("sadc_sar: unsupported parameters");
    end

    // Each bit waits STEP cycles so the comparator result has passed its synchroniser.
    always_ff @(posedge clk)
    begin
        done <= 1'b0;
        if (!rstn)
        begin
            mask_reg <= '0;
            trial <= '0;
            busy <= 1'b0;
            wait_reg <= '0;
        end
        else if (!busy)
        begin
            if (go)
            begin
                busy <= 1'b1;
                mask_reg <= {1'b1, {(BITS-1){1'b0}}};
                trial <= {1'b1, {(BITS-1){1'b0}}};
                wait_reg <= 16'(STEP);
            end
        end
        else if (wait_reg != 16'h0001)
            wait_reg <= wait_reg - 16'h0001;
        else
        begin
            wait_reg <= 16'(STEP);
            mask_reg <= mask_reg >> 1;
            trial <= (cmp_hi ? trial : (trial & ~mask_reg)) | (mask_reg >> 1);
            if (mask_reg[0])
            begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end
    end
endmodule

// ===== dv/sadc_src_model.sv
// Analog source and comparator model facing the converter pins.
`timescale 1ns/100ps
module sadc_src_model
    import sadc_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Converter side.
    input wire logic [3:0] sel,
    input wire sadc_code_t trial,
    input wire logic [23:0] codes,
    output logic cmp_hi
);
    logic alt = 1'b0;
    logic [5:0] lvl;
    // An idle comparator toggles so that a stale decision is never mistaken for a real one.
    always_ff @(posedge clk)
    begin
        alt <= ~alt;
    end
    // Each level sits half a step above its code, so a trial equal to it reads high.
    always_comb
    begin
        lvl = 6'h00;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                lvl = codes[i*6 +: 6];
            end
        end
        cmp_hi = (sel == 4'h0) ? alt : ({lvl, 1'b1} > {trial, 1'b0});
    end
endmodule

// ===== dv/sadc_top_tb.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
module sadc_top_tb;
    import sadc_pkg::*;
    logic clk;
    logic rstn;
    sadc_bus_s b;
    logic [7:0] rdata;
    logic cmp_hi;
    logic [3:0] ch_sel;
    sadc_code_t trial;
    logic [3:0] pin_an;
    logic irq;
    logic [23:0] codes;
    logic [7:0] rq;
    int failures = 0;
    int n_checks = 0;
    logic [7:0] rst_a [7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h1B, 8'h1E, 8'h20};
    logic [7:0] rst_e [7] = '{8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    sadc_top u_dut (.CLK(clk), .RSTN(rstn), .BUS(b), .RDATA(rdata), .CMP_HI(cmp_hi),
        .CH_SELECT(ch_sel), .TRIAL_CODE(trial), .PIN_IS_ANALOG(pin_an), .IRQ(irq));
    sadc_src_model u_src (.clk(clk), .sel(ch_sel), .trial(trial), .codes(codes),
        .cmp_hi(cmp_hi));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        b <= {a, d, 2'b10};
        @(posedge clk);
        b.wr <= 1'b0;
    endtask

    // Read data live only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        b <= {a, 8'h00, 2'b01};
        @(posedge clk);
        b.rd <= 1'b0;
        @(negedge clk);
        rq = rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rq, e);
    endtask

    task automatic give_up();
        failures++;
        $display("FAIL %0t wait ran out", $time);
        end_sim();
    endtask

    task automatic wait_irq(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            @(negedge clk);
            if (irq === lvl)
                break;
        end
        if (i == lim)
            give_up();
    endtask

    task automatic poll_done(input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            rd(8'h1E);
            if (rq === 8'h08)
                break;
        end
        if (i == lim)
            give_up();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        b = '0;
        codes = {6'h01, 6'h3F, 6'h15, 6'h2A};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 7; i++)
        begin
            rdchk(rst_a[i], rst_e[i]);
        end
        chk({4'h0, pin_an}, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr(8'h1B, 8'h08);
        rdchk(8'h1B, 8'h08);
        wr(8'h11, 8'h3F);
        rdchk(8'h11, 8'hC0);
        // Channels 0 and 2 only; the other latches must keep their old contents.
        wr(8'h10, 8'h7A);
        rdchk(8'h1E, 8'h00);
        chk({4'h0, pin_an}, 8'h05);
        wait_irq(1'b1, 600);
        rdchk(8'h1E, 8'h08);
        rdchk(8'h11, 8'hEA);
        rdchk(8'h12, 8'h00);
        rdchk(8'h13, 8'h3F);
        rdchk(8'h14, 8'h00);
        wr(8'h1E, 8'h00);
        rdchk(8'h1E, 8'h08);
        chk({7'h00, irq}, 8'h01);
        wr(8'h1E, 8'h08);
        wait_irq(1'b0, 3);
        rdchk(8'h1E, 8'h00);
        // Masked run on all channels, with both ends of the code range.
        wr(8'h1B, 8'h00);
        codes <= {6'h3F, 6'h20, 6'h15, 6'h00};
        wr(8'h10, 8'h70);
        poll_done(200);
        chk({7'h00, irq}, 8'h00);
        rdchk(8'h11, 8'hC0);
        rdchk(8'h12, 8'h15);
        rdchk(8'h13, 8'h20);
        rdchk(8'h14, 8'h3F);
        chk({4'h0, pin_an}, 8'h0F);
        wr(8'h1B, 8'h08);
        wait_irq(1'b1, 3);
        // Reset in mid-conversion with a request still pending.
        wr(8'h10, 8'h70);
        repeat (20) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rdchk(8'h1B, 8'h00);
        rdchk(8'h1E, 8'h00);
        rdchk(8'h11, 8'hC0);
        chk({7'h00, irq}, 8'h00);
        chk({4'h0, pin_an}, 8'h00);
        repeat (300) @(posedge clk);
        rdchk(8'h1E, 8'h00);
        chk({4'h0, ch_sel}, 8'h00);
        end_sim();
    end
endmodule
